// file: shared/mpc_pkg.sv
package mpc_pkg;

  // software register offsets (byte addresses)
  localparam int          REG_AW           = 8;
  localparam logic [7:0]  OFS_CTRL         = 8'h00;
  localparam logic [7:0]  OFS_BOUND        = 8'h04;
  localparam logic [7:0]  OFS_STATUS       = 8'h08;
  localparam logic [7:0]  OFS_FETCH_CNT    = 8'h0c;
  localparam logic [7:0]  OFS_CANCEL_CNT   = 8'h10;
  localparam logic [7:0]  OFS_DACC_CNT     = 8'h14;
  localparam logic [7:0]  OFS_FAULT_CNT    = 8'h18;
  localparam logic [7:0]  OFS_HINT_CNT     = 8'h1c;

  // control register fields
  localparam int          CTRL_WAIT_LSB    = 0;
  localparam int          CTRL_WAIT_W      = 4;
  localparam int          CTRL_PROT_BIT    = 4;
  localparam logic [3:0]  CTRL_WAIT_RST    = 4'h0;
  localparam logic        CTRL_PROT_RST    = 1'b0;
  localparam logic [31:0] BOUND_RST        = 32'h0000_0000;

  // status register fields
  localparam int          STAT_LOCK_BIT    = 0;
  localparam int          STAT_PRIV_BIT    = 1;
  localparam int          STAT_MODE_LSB    = 8;

  // transfer size encodings
  localparam logic [1:0]  SIZE_BYTE        = 2'h0;
  localparam logic [1:0]  SIZE_HALF        = 2'h1;
  localparam logic [1:0]  SIZE_WORD        = 2'h2;

  localparam logic [3:0]  BE_NONE          = 4'h0;
  localparam logic [3:0]  BE_WORD          = 4'hf;
  localparam logic [3:0]  BE_HALF_LO       = 4'h3;
  localparam logic [3:0]  BE_HALF_HI       = 4'hc;
  localparam logic [3:0]  BE_BYTE0         = 4'h1;

  // address-class and request signals of the load/store port
  typedef struct packed {
    logic        request_n;
    logic        sequential;
    logic [31:0] address;
    logic        atomic_hold;
    logic [1:0]  size;
    logic [4:0]  mode_inv;
    logic        write_dir;
    logic        hint_n;
    logic        privilege;
  } mpc_ls_req_s;

  // instruction fetch request signals
  typedef struct packed {
    logic        request_n;
    logic        sequential;
    logic [31:0] address;
  } mpc_fetch_req_s;

  // software command port
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mpc_sw_req_s;

  typedef enum logic {
    MPC_RUN,
    MPC_STALL
  } mpc_phase_e;

endpackage : mpc_pkg

// file: rtl/mpc_word_ram.sv
`timescale 1ns/1ps

// one write port with byte enables, two read ports; reads return the
// byte being written in the same cycle so back-to-back store/load agree
module mpc_word_ram #(
  parameter int AW = 10
) (
  input  wire logic          clock_i,
  input  wire logic [AW-1:0] w_addr_i,
  input  wire logic [3:0]    w_be_i,
  input  wire logic [31:0]   w_data_i,
  input  wire logic          a_en_i,
  input  wire logic [AW-1:0] a_addr_i,
  output wire logic [31:0]   a_data_o,
  input  wire logic          b_en_i,
  input  wire logic [AW-1:0] b_addr_i,
  output wire logic [31:0]   b_data_o
);

  localparam int DEPTH = 1 << AW;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : lane
      logic [7:0] mem [DEPTH];
      logic [7:0] a_q;
      logic [7:0] b_q;

      always_ff @(posedge clock_i)
      begin
        if (w_be_i[g])
        begin
          mem[w_addr_i] <= w_data_i[g*8 +: 8];
        end
        if (a_en_i)
        begin
          a_q <= (w_be_i[g] && w_addr_i == a_addr_i) ? w_data_i[g*8 +: 8] : mem[a_addr_i];
        end
        if (b_en_i)
        begin
          b_q <= (w_be_i[g] && w_addr_i == b_addr_i) ? w_data_i[g*8 +: 8] : mem[b_addr_i];
        end
      end

      assign a_data_o[g*8 +: 8] = a_q;
      assign b_data_o[g*8 +: 8] = b_q;
    end
  endgenerate

endmodule : mpc_word_ram

// file: rtl/mpc_mem_ctrl.sv
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

// Operation
// - cancelled fetch leaves no visible state; the code still counts it in cancel_cnt, readable by software
// - fetch request qualified by cancel before use
// - cancelled fetch starts no bus transaction; the code reads port b on every fetch request, before cancel is sampled
// - data access only on request, never direction
// - all signals on rising clock edge
// - stretch cycles by holding enable low
// - ignore low address bits by size
// - keep bus granted during locked transfers
// - writable memory has per-byte write enables
// - hint never aborted, never with request
// - fault sampled at end of active cycles
// - read data sampled at cycle end
// - fetch request/sequential encode cycle type
// - load/store request/sequential encode cycle type
module mpc_mem_ctrl #(
  parameter int AW = 10
) (
  input  wire logic                   clock_i,
  input  wire logic                   srst_i,
  input  wire mpc_pkg::mpc_sw_req_s   sw_req_i,
  output logic [31:0]                 sw_rdata_o,
  input  wire mpc_pkg::mpc_fetch_req_s fetch_req_i,
  input  wire logic                   fetch_cancel_i,
  output wire logic [31:0]            fetch_rdata_o,
  input  wire mpc_pkg::mpc_ls_req_s   ls_req_i,
  input  wire logic [31:0]            ls_wdata_i,
  output wire logic [31:0]            ls_rdata_o,
  output logic                        ls_fault_o,
  output logic                        cycle_advance_enable_o,
  output logic                        bus_locked_o
);

  typedef struct packed {
    mpc_pkg::mpc_phase_e phase;
    logic                adv_en;
    logic [3:0]          stall_cnt;
    logic                f_pend;
    logic                d_pend;
    logic                d_write;
    logic [1:0]          d_size;
    logic [31:0]         d_addr;
    logic                d_fault;
    logic                locked;
    logic [4:0]          last_mode;
    logic                last_priv;
    logic [3:0]          wait_cfg;
    logic                prot_en;
    logic [31:0]         bound;
    logic [31:0]         fetch_cnt;
    logic [31:0]         cancel_cnt;
    logic [31:0]         dacc_cnt;
    logic [31:0]         fault_cnt;
    logic [31:0]         hint_cnt;
    logic [31:0]         sw_rdata;
  } mpc_state_s;

  mpc_state_s q;
  mpc_state_s d;

  logic          ls_commit;
  logic          f_commit;
  logic          ram_a_en;
  logic          ram_b_en;
  logic [3:0]    ram_be;

  always_comb
  begin
    d         = q;
    ram_be    = mpc_pkg::BE_NONE;
    ram_a_en  = 1'b0;
    ram_b_en  = 1'b0;
    // internal and coprocessor cycles never touch memory
    ls_commit = ~ls_req_i.request_n;
    f_commit  = ~fetch_req_i.request_n;

    if (sw_req_i.wr)
    begin
      case (sw_req_i.addr)
        mpc_pkg::OFS_CTRL:
        begin
          d.wait_cfg = sw_req_i.wdata[mpc_pkg::CTRL_WAIT_LSB +: mpc_pkg::CTRL_WAIT_W];
          d.prot_en  = sw_req_i.wdata[mpc_pkg::CTRL_PROT_BIT];
        end
        mpc_pkg::OFS_BOUND:      d.bound      = sw_req_i.wdata;
        mpc_pkg::OFS_FETCH_CNT:  d.fetch_cnt  = 32'h0;
        mpc_pkg::OFS_CANCEL_CNT: d.cancel_cnt = 32'h0;
        mpc_pkg::OFS_DACC_CNT:   d.dacc_cnt   = 32'h0;
        mpc_pkg::OFS_FAULT_CNT:  d.fault_cnt  = 32'h0;
        mpc_pkg::OFS_HINT_CNT:   d.hint_cnt   = 32'h0;
        default:                 d.bound      = q.bound;
      endcase
    end

    d.sw_rdata = 32'h0;
    if (sw_req_i.rd)
    begin
      case (sw_req_i.addr)
        mpc_pkg::OFS_CTRL:
        begin
          d.sw_rdata[mpc_pkg::CTRL_WAIT_LSB +: mpc_pkg::CTRL_WAIT_W] = q.wait_cfg;
          d.sw_rdata[mpc_pkg::CTRL_PROT_BIT] = q.prot_en;
        end
        mpc_pkg::OFS_BOUND:      d.sw_rdata = q.bound;
        mpc_pkg::OFS_STATUS:
        begin
          d.sw_rdata[mpc_pkg::STAT_LOCK_BIT] = q.locked;
          d.sw_rdata[mpc_pkg::STAT_PRIV_BIT] = q.last_priv;
          d.sw_rdata[mpc_pkg::STAT_MODE_LSB +: 5] = q.last_mode;
        end
        mpc_pkg::OFS_FETCH_CNT:  d.sw_rdata = q.fetch_cnt;
        mpc_pkg::OFS_CANCEL_CNT: d.sw_rdata = q.cancel_cnt;
        mpc_pkg::OFS_DACC_CNT:   d.sw_rdata = q.dacc_cnt;
        mpc_pkg::OFS_FAULT_CNT:  d.sw_rdata = q.fault_cnt;
        mpc_pkg::OFS_HINT_CNT:   d.sw_rdata = q.hint_cnt;
        default:                 d.sw_rdata = 32'h0;
      endcase
    end

    case (q.phase)
      mpc_pkg::MPC_RUN:
      begin
        // the core only moves on edges where our enable was high
        if (q.adv_en)
        begin
          // data phase of the previous request ends here
          if (q.d_pend)
          begin
            d.dacc_cnt = q.dacc_cnt + 32'h1;
            if (q.d_fault)
            begin
              d.fault_cnt = q.fault_cnt + 32'h1;
            end
            else if (q.d_write)
            begin
              case (q.d_size)
                mpc_pkg::SIZE_WORD: ram_be = mpc_pkg::BE_WORD;
                mpc_pkg::SIZE_HALF: ram_be = q.d_addr[1] ? mpc_pkg::BE_HALF_HI
                                                           : mpc_pkg::BE_HALF_LO;
                mpc_pkg::SIZE_BYTE: ram_be = mpc_pkg::BE_BYTE0 << q.d_addr[1:0];
                default:            ram_be = mpc_pkg::BE_NONE;
              endcase
            end
          end
          // cancel is stable between enabled edges, so sampling here is safe
          if (q.f_pend)
          begin
            if (fetch_cancel_i)
            begin
              // lookup already done is harmless; only the count is kept
              d.cancel_cnt = q.cancel_cnt + 32'h1;
            end
            else
            begin
              d.fetch_cnt = q.fetch_cnt + 32'h1;
            end
          end

          // address phase of the next request
          d.d_pend  = ls_commit;
          d.d_write = ls_req_i.write_dir;
          d.d_size  = ls_req_i.size;
          d.d_addr  = ls_req_i.address;
          // user accesses at or above the bound abort; a hint carries no request
          d.d_fault = ls_commit & q.prot_en & ~ls_req_i.privilege &
                      (ls_req_i.address >= q.bound);
          ram_a_en  = ls_commit & ~ls_req_i.write_dir;
          d.f_pend  = f_commit;
          ram_b_en  = f_commit;
          d.locked  = ls_req_i.atomic_hold;
          if (ls_commit)
          begin
            d.last_mode = ~ls_req_i.mode_inv;
            d.last_priv = ls_req_i.privilege;
          end
          if (ls_req_i.request_n && !ls_req_i.hint_n)
          begin
            d.hint_cnt = q.hint_cnt + 32'h1;
          end
          if ((ls_commit || f_commit) && q.wait_cfg != 4'h0)
          begin
            d.adv_en    = 1'b0;
            d.stall_cnt = q.wait_cfg - 4'h1;
            d.phase     = mpc_pkg::MPC_STALL;
          end
        end
      end
      mpc_pkg::MPC_STALL:
      begin
        if (q.stall_cnt == 4'h0)
        begin
          d.adv_en = 1'b1;
          d.phase  = mpc_pkg::MPC_RUN;
        end
        else
        begin
          d.stall_cnt = q.stall_cnt - 4'h1;
        end
      end
      default:
      begin
        d.adv_en = 1'b1;
        d.phase  = mpc_pkg::MPC_RUN;
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      q            <= '0;
      q.phase      <= mpc_pkg::MPC_RUN;
      q.adv_en     <= 1'b1;
      q.wait_cfg   <= mpc_pkg::CTRL_WAIT_RST;
      q.prot_en    <= mpc_pkg::CTRL_PROT_RST;
      q.bound      <= mpc_pkg::BOUND_RST;
    end
    else
    begin
      q <= d;
    end
  end

  mpc_word_ram #(
    .AW (AW)
  ) u_ram (
    .clock_i  (clock_i),
    .w_addr_i (q.d_addr[AW+1:2]),
    .w_be_i   (ram_be),
    .w_data_i (ls_wdata_i),
    .a_en_i   (ram_a_en),
    .a_addr_i (ls_req_i.address[AW+1:2]),
    .a_data_o (ls_rdata_o),
    .b_en_i   (ram_b_en),
    .b_addr_i (fetch_req_i.address[AW+1:2]),
    .b_data_o (fetch_rdata_o)
  );

  assign sw_rdata_o             = q.sw_rdata;
  assign ls_fault_o             = q.d_fault;
  assign cycle_advance_enable_o = q.adv_en;
  assign bus_locked_o           = q.locked;

endmodule : mpc_mem_ctrl

// file: tb/mpc_mem_ctrl_checker.sv
`timescale 1ns/1ps

module mpc_mem_ctrl_checker (
  input wire logic                    clock_i,
  input wire logic                    srst_i,
  input wire mpc_pkg::mpc_sw_req_s    sw_req_i,
  input wire logic [31:0]             sw_rdata_o,
  input wire mpc_pkg::mpc_fetch_req_s fetch_req_i,
  input wire logic [31:0]             fetch_rdata_o,
  input wire mpc_pkg::mpc_ls_req_s    ls_req_i,
  input wire logic [31:0]             ls_rdata_o,
  input wire logic                    ls_fault_o,
  input wire logic                    cycle_advance_enable_o,
  input wire logic                    bus_locked_o
);
  logic [4:0] low_q;
  logic [4:0] low_d;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  // stall length, at most the largest wait setting
  always_comb low_d = cycle_advance_enable_o ? 5'h0 : low_q + 5'h1;
  always_ff @(posedge clock_i) low_q <= srst_i ? 5'h0 : low_d;

  property p_sw_idle; !sw_req_i.rd |=> sw_rdata_o == 32'h0; endproperty
  a_sw_idle: assert property (p_sw_idle) else $error("read data outside slot");
  property p_lock_copy;
    cycle_advance_enable_o |=> bus_locked_o == $past(ls_req_i.atomic_hold);
  endproperty
  a_lock_copy: assert property (p_lock_copy) else $error("lock not followed");
  property p_lock_hold; !cycle_advance_enable_o |=> $stable(bus_locked_o); endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock moved in stall");
  property p_idle_run;
    cycle_advance_enable_o && ls_req_i.request_n && fetch_req_i.request_n
      |=> cycle_advance_enable_o;
  endproperty
  a_idle_run: assert property (p_idle_run) else $error("stall without request");
  property p_stall_bound; low_q < 5'h10; endproperty
  a_stall_bound: assert property (p_stall_bound) else $error("stall too long");
  property p_stall_cause;
    $fell(cycle_advance_enable_o)
      |-> $past(ls_req_i.request_n) == 1'b0 || $past(fetch_req_i.request_n) == 1'b0;
  endproperty
  a_stall_cause: assert property (p_stall_cause) else $error("stall not after request");
  property p_rdata_hold;
    !cycle_advance_enable_o |=> $stable(ls_rdata_o) && $stable(fetch_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved in stall");
  property p_fault_hold; !cycle_advance_enable_o |=> $stable(ls_fault_o); endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault moved in stall");
  property p_hint_safe;
    cycle_advance_enable_o && ls_req_i.request_n |=> !$rose(ls_fault_o);
  endproperty
  a_hint_safe: assert property (p_hint_safe) else $error("fault without access");
endmodule : mpc_mem_ctrl_checker

bind mpc_mem_ctrl mpc_mem_ctrl_checker mpc_mem_ctrl_checker_inst (.clock_i, .srst_i,
  .sw_req_i, .sw_rdata_o, .fetch_req_i, .fetch_rdata_o, .ls_req_i, .ls_rdata_o,
  .ls_fault_o, .cycle_advance_enable_o, .bus_locked_o);

// file: tb/mpc_core_model.sv
`timescale 1ns/1ps

module mpc_core_model (
  input  wire logic               clock_i,
  input  wire logic               en_i,
  input  wire logic [31:0]        fetch_rdata_i,
  input  wire logic [31:0]        ls_rdata_i,
  input  wire logic               ls_fault_i,
  output mpc_pkg::mpc_fetch_req_s fetch_req_o,
  output logic                    fetch_cancel_o,
  output mpc_pkg::mpc_ls_req_s    ls_req_o,
  output logic [31:0]             ls_wdata_o
);
  localparam mpc_pkg::mpc_ls_req_s ls_idle = '{1'b1, 1'b0, 32'h0, 1'b0, 2'h2, 5'h1f,
                                               1'b0, 1'b1, 1'b0};
  logic [7:0] n_stall;

  initial
  begin
    fetch_req_o = '{1'b1, 1'b0, 32'h0};
    fetch_cancel_o = 1'b0;
    ls_req_o = ls_idle;
    ls_wdata_o = 32'h0;
    n_stall = 8'h0;
  end

  // one enabled edge; edges with the enable low only stretch the cycle
  task automatic edge_en();
    n_stall = 8'h0;
    @(posedge clock_i);
    while (en_i !== 1'b1)
    begin
      n_stall = n_stall + 8'h1;
      @(posedge clock_i);
    end
  endtask : edge_en

  // single accesses only, so no burst can change size or direction
  task automatic ls_op(input logic n, input logic wr, input logic [31:0] a,
                       input logic [1:0] sz, input logic [31:0] wd,
                       input logic [6:0] at, output logic [31:0] rd, output logic flt);
    ls_req_o <= '{n, n, a, at[6], sz, ~at[4:0], wr, ~n, at[5]};
    edge_en();
    ls_req_o <= ls_idle;
    ls_wdata_o <= wd;
    edge_en();
    rd = ls_rdata_i;
    flt = ls_fault_i;
  endtask : ls_op

  task automatic fetch(input logic [31:0] a, input logic kill, output logic [31:0] rd);
    fetch_req_o <= '{1'b0, 1'b0, a};
    edge_en();
    fetch_req_o <= '{1'b1, 1'b0, a};
    fetch_cancel_o <= kill;
    edge_en();
    fetch_cancel_o <= 1'b0;
    rd = fetch_rdata_i;
  endtask : fetch
endmodule : mpc_core_model

// file: tb/tb_mpc_mem_ctrl.sv
`timescale 1ns/1ps

module tb_mpc_mem_ctrl;
  logic                    clock_i;
  logic                    srst_i;
  mpc_pkg::mpc_sw_req_s    sw_req;
  logic [31:0]             sw_rdata;
  mpc_pkg::mpc_fetch_req_s fetch_req;
  logic                    fetch_cancel;
  logic [31:0]             fetch_rdata;
  mpc_pkg::mpc_ls_req_s    ls_req;
  logic [31:0]             ls_wdata;
  logic [31:0]             ls_rdata;
  logic                    ls_fault;
  logic                    cae;
  logic                    locked;
  logic [31:0]             d;
  logic                    f;
  int                      n_errors = 0;
  int                      checked = 0;
  int                      cyc = 0;

  mpc_mem_ctrl mpc_mem_ctrl_inst (.clock_i(clock_i), .srst_i(srst_i), .sw_req_i(sw_req),
    .sw_rdata_o(sw_rdata), .fetch_req_i(fetch_req), .fetch_cancel_i(fetch_cancel),
    .fetch_rdata_o(fetch_rdata), .ls_req_i(ls_req), .ls_wdata_i(ls_wdata),
    .ls_rdata_o(ls_rdata), .ls_fault_o(ls_fault), .cycle_advance_enable_o(cae),
    .bus_locked_o(locked));
  mpc_core_model mpc_core_model_inst (.clock_i(clock_i), .en_i(cae),
    .fetch_rdata_i(fetch_rdata), .ls_rdata_i(ls_rdata), .ls_fault_i(ls_fault),
    .fetch_req_o(fetch_req), .fetch_cancel_o(fetch_cancel), .ls_req_o(ls_req),
    .ls_wdata_o(ls_wdata));

  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic sw_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    sw_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clock_i);
    sw_req.wr <= 1'b0;
  endtask : sw_wr

  task automatic sw_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock_i);
    sw_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clock_i);
    sw_req.rd <= 1'b0;
    @(posedge clock_i);
    v = sw_rdata;
  endtask : sw_rd

  task automatic ls(input logic n, input logic wr, input logic [31:0] a,
                    input logic [1:0] sz, input logic [31:0] wd, input logic [6:0] at);
    mpc_core_model_inst.ls_op(n, wr, a, sz, wd, at, d, f);
  endtask : ls

  initial
  begin
    srst_i = 1'b1;
    sw_req = '0;
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      sw_rd(8'(4 * i), d);
      chk("reset reg", 32'h0, d);
    end
    ls(1'b0, 1'b1, 32'h103, 2'h2, 32'h1122_3344, 7'h2a);
    ls(1'b0, 1'b1, 32'h102, 2'h0, 32'h5a5a_5a5a, 7'h2a);
    ls(1'b0, 1'b1, 32'h101, 2'h1, 32'ha5b6_a5b6, 7'h2a);
    ls(1'b0, 1'b1, 32'h100, 2'h3, 32'hffff_ffff, 7'h2a);
    ls(1'b1, 1'b1, 32'h100, 2'h2, 32'h0bad_0bad, 7'h2a);
    ls(1'b0, 1'b0, 32'h100, 2'h2, 32'h0, 7'h6a);
    chk("load word", 32'h115a_a5b6, d);
    sw_rd(mpc_pkg::OFS_STATUS, d);
    chk("status", 32'h0a02, d & 32'h1f03);
    mpc_core_model_inst.fetch(32'h100, 1'b0, d);
    chk("fetch word", 32'h115a_a5b6, d);
    // written word keeps the port b output known for the stall checks
    mpc_core_model_inst.fetch(32'h100, 1'b1, d);
    sw_rd(mpc_pkg::OFS_FETCH_CNT, d);
    chk("fetch count", 32'h1, d);
    sw_rd(mpc_pkg::OFS_CANCEL_CNT, d);
    chk("cancel count", 32'h1, d);
    sw_rd(mpc_pkg::OFS_HINT_CNT, d);
    chk("hint count", 32'h1, d);
    sw_wr(mpc_pkg::OFS_CTRL, 32'h3);
    ls(1'b0, 1'b0, 32'h100, 2'h2, 32'h0, 7'h2a);
    chk("stall", 32'h3, 32'(mpc_core_model_inst.n_stall));
    chk("slow load", 32'h115a_a5b6, d);
    sw_wr(mpc_pkg::OFS_CTRL, 32'h10);
    sw_wr(mpc_pkg::OFS_BOUND, 32'h200);
    ls(1'b0, 1'b1, 32'h300, 2'h2, 32'hcafe_0001, 7'h2a);
    chk("priv fault", 32'h0, 32'(f));
    ls(1'b0, 1'b1, 32'h300, 2'h2, 32'h0bad_0002, 7'h05);
    chk("user fault", 32'h1, 32'(f));
    ls(1'b0, 1'b0, 32'h300, 2'h2, 32'h0, 7'h2a);
    chk("faulted store", 32'hcafe_0001, d);
    sw_rd(mpc_pkg::OFS_FAULT_CNT, d);
    chk("fault count", 32'h1, d);
    // every committed access counts, faulted or reserved size included
    sw_rd(mpc_pkg::OFS_DACC_CNT, d);
    chk("access count", 32'h9, d);
    sw_wr(mpc_pkg::OFS_FAULT_CNT, 32'h0);
    sw_rd(mpc_pkg::OFS_FAULT_CNT, d);
    chk("fault count clear", 32'h0, d);
    end_sim();
  end
endmodule : tb_mpc_mem_ctrl
